/* rtl/ubff_params.svh */
// Purpose: Constants for the serial baud and frame-format block
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes: Register offsets below are byte addresses of aligned words
//
// Overview of operation
// - Baud rate is clock over two to the n+1 times k+16.
// - Three-bit prescale field picks clock over 2^(n+1), n is field plus one.
// - Five-bit counter divides prescaled clock by 16+k, k from 0 to 14.
// - Frame is start bit, character bits, optional parity, then stop bits.
// - Seven-bit mode sends data bits 0 to 6 and ignores bit 7.
// - Seven-bit mode presents received bit 7 as zero.
// - Transmitter sends one or two stop bits per frame.
// - Even, odd, zero, none parity; parity errors flagged only for even and odd.
// - Even mode transmit parity is one when character has odd ones.
// - Even mode receive flags error when ones plus parity is odd.
// - Odd mode transmit parity is zero when character has odd ones.
// - Odd mode receive flags error when ones plus parity is even.
// - Receive errors are recorded in a readable status register.
// - Parity field: 00 none, 01 zero, 10 odd, 11 even.
// - Stop-length bit: 0 gives one stop bit, 1 gives two.
// - Receiver checks only the first stop bit for framing.
// - Length bit: 0 gives seven-bit, 1 gives eight-bit characters.
`ifndef UBFF_PARAMS_SVH
`define UBFF_PARAMS_SVH
`define UBFF_OFS_MODE 8'h00
`define UBFF_OFS_ERRSTAT 8'h04
`define UBFF_OFS_BAUD 8'h08
`define UBFF_OFS_TXDATA 8'h0C
`define UBFF_OFS_RXDATA 8'h10
`define UBFF_OFS_IRQSTAT 8'h14
`define UBFF_OFS_IRQMASK 8'h18
`define UBFF_MODE_RST 8'h00
`define UBFF_BAUD_RST 8'h00
`define UBFF_MODE_TXE 7
`define UBFF_MODE_RXE 6
`define UBFF_MODE_PARH 4
`define UBFF_MODE_PARL 3
`define UBFF_MODE_CLEN 2
`define UBFF_MODE_SLEN 1
`define UBFF_BAUD_PSH 6
`define UBFF_BAUD_PSL 4
`define UBFF_BAUD_DVH 3
`define UBFF_BAUD_DVL 0
`define UBFF_DIV_BASE 5'h10
`define UBFF_DIV_KMAX 4'hE
`define UBFF_IRQ_TXDONE 0
`define UBFF_IRQ_RXDONE 1
`define UBFF_IRQ_RXERR 2
`endif

/* rtl/ubff_pkg.sv */
// Purpose: Types for the serial baud and frame-format block
// Assumes: Constants live in ubff_params.svh
// Notes: One-hot state codes written out
package ubff_pkg;
	typedef enum logic [1:0] {
		UBFF_PAR_NONE = 2'h0,
		UBFF_PAR_ZERO = 2'h1,
		UBFF_PAR_ODD = 2'h2,
		UBFF_PAR_EVEN = 2'h3
	} ubff_parity_t;
	typedef enum logic [5:0] {
		UBFF_IDLE = 6'h01,
		UBFF_START = 6'h02,
		UBFF_DATA = 6'h04,
		UBFF_PARITY = 6'h08,
		UBFF_STOP1 = 6'h10,
		UBFF_STOP2 = 6'h20
	} ubff_state_t;
	typedef struct packed {
		logic txEnable;
		logic rxEnable;
		ubff_parity_t parity;
		logic eightBit;
		logic twoStop;
	} ubff_mode_t;
	typedef struct packed {
		logic parityErr;
		logic framingErr;
		logic overrunErr;
	} ubff_err_t;
endpackage

/* rtl/ubff_uart.sv */
// Purpose: UART baud generator, frame formatter, parity and receive errors
// Assumes: Single 50 MHz clock, synchronous active-high reset, rxLine synchronous
// Notes: Registers reached over classic Wishbone; one level interrupt
`include "ubff_params.svh"
`timescale 1ns/10ps
`default_nettype none
module ubff_uart (
	input wire logic clk, // System clock
	input wire logic reset, // Synchronous reset, active high
	input wire logic wbCyc, // Wishbone cycle
	input wire logic wbStb, // Wishbone strobe
	input wire logic wbWe, // Wishbone write enable
	input wire logic [7:0] wbAdr, // Wishbone byte address
	input wire logic [3:0] wbSel, // Wishbone byte selects
	input wire logic [31:0] wbDatI, // Wishbone write data
	output logic [31:0] wbDatO, // Wishbone read data
	output logic wbAck, // Wishbone acknowledge
	input wire logic rxLine, // Serial receive line
	output logic txLine, // Serial transmit line
	output logic irq // Interrupt, active high level
);
	logic [7:0] modeReg_q;
	logic [7:0] baudReg_q;
	logic [2:0] irqStat_q;
	logic [2:0] irqMask_q;
	ubff_pkg::ubff_err_t errStat_q;
	logic [7:0] rxBuf_q;
	logic rxFull_q;
	ubff_pkg::ubff_mode_t mode;
	logic wbReq, wbWrite, wbRead;
	logic [8:0] prescale_q;
	logic [2:0] presSel;
	logic tick;
	logic [4:0] txCnt_q, rxCnt_q, divLen;
	logic txTick, rxTick, rxMid;
	ubff_pkg::ubff_state_t txState_q, rxState_q;
	logic [7:0] txShift_q, rxShift_q;
	logic [2:0] txBits_q, rxBits_q;
	logic txPar_q, rxPar_q;
	logic txStart, txDone, rxDone;
	ubff_pkg::ubff_err_t rxErr;
	logic rxStopOk;

	function automatic logic selByte(input logic [7:0] adr, input logic [7:0] ofs, input logic [3:0] sel);
		selByte = (adr[7:2] == ofs[7:2]) && sel[0];
	endfunction

	// Seven-bit characters keep only bits 0 to 6
	function automatic logic [7:0] charMask(input logic [7:0] d, input logic eight);
		charMask = eight ? d : {1'b0, d[6:0]};
	endfunction

	assign mode.txEnable = modeReg_q[`UBFF_MODE_TXE];
	assign mode.rxEnable = modeReg_q[`UBFF_MODE_RXE];
	assign mode.parity = ubff_pkg::ubff_parity_t'(modeReg_q[`UBFF_MODE_PARH:`UBFF_MODE_PARL]);
	assign mode.eightBit = modeReg_q[`UBFF_MODE_CLEN];
	assign mode.twoStop = modeReg_q[`UBFF_MODE_SLEN];

	assign wbReq = wbCyc && wbStb && !wbAck;
	assign wbWrite = wbReq && wbWe;
	assign wbRead = wbReq && !wbWe;
	assign txStart = wbWrite && selByte(wbAdr, `UBFF_OFS_TXDATA, wbSel) && mode.txEnable
		&& (txState_q == ubff_pkg::UBFF_IDLE);

	// Bus slave: one wait state, ack one cycle after request seen
	always_ff @(posedge clk) begin
		if (reset) begin
			wbAck <= 1'b0;
			wbDatO <= 32'h0000_0000;
		end else begin
			wbAck <= wbReq;
			wbDatO <= 32'h0000_0000;
			if (wbRead) begin
				case (wbAdr[7:2])
					6'(`UBFF_OFS_MODE >> 2): wbDatO <= {24'h000000, modeReg_q};
					6'(`UBFF_OFS_ERRSTAT >> 2): wbDatO <= {29'h00000000, errStat_q};
					6'(`UBFF_OFS_BAUD >> 2): wbDatO <= {24'h000000, baudReg_q};
					6'(`UBFF_OFS_RXDATA >> 2): wbDatO <= {24'h000000, rxBuf_q};
					6'(`UBFF_OFS_IRQSTAT >> 2): wbDatO <= {29'h00000000, irqStat_q};
					6'(`UBFF_OFS_IRQMASK >> 2): wbDatO <= {29'h00000000, irqMask_q};
					default: wbDatO <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			modeReg_q <= `UBFF_MODE_RST;
			baudReg_q <= `UBFF_BAUD_RST;
			irqMask_q <= 3'h0;
		end else if (wbWrite) begin
			if (selByte(wbAdr, `UBFF_OFS_MODE, wbSel))
				modeReg_q <= {wbDatI[7:1], 1'b0};
			if (selByte(wbAdr, `UBFF_OFS_BAUD, wbSel))
				baudReg_q <= {1'b0, wbDatI[6:0]};
			if (selByte(wbAdr, `UBFF_OFS_IRQMASK, wbSel))
				irqMask_q <= wbDatI[2:0];
		end
	end

	// Prescaler: tick every 2^(field+2) clocks, which with the 16+k divider gives the baud formula
	assign presSel = baudReg_q[`UBFF_BAUD_PSH:`UBFF_BAUD_PSL];
	always_ff @(posedge clk) begin
		if (reset)
			prescale_q <= 9'h000;
		else
			prescale_q <= prescale_q + 9'h001;
	end
	always_comb begin
		tick = 1'b1;
		for (int i = 0; i < 9; i++) begin
			if (i <= int'(presSel) + 1)
				tick = tick & prescale_q[i];
		end
	end

	// Divide-by-16+k counters; k above 14 is clamped
	always_comb begin
		divLen = `UBFF_DIV_BASE + 5'((baudReg_q[3:0] > `UBFF_DIV_KMAX) ? `UBFF_DIV_KMAX : baudReg_q[3:0]);
	end
	assign txTick = tick && (txCnt_q == divLen - 5'h01);
	assign rxTick = tick && (rxCnt_q == divLen - 5'h01);
	assign rxMid = tick && (rxCnt_q == (divLen >> 1));

	always_ff @(posedge clk) begin
		if (reset || txState_q == ubff_pkg::UBFF_IDLE)
			txCnt_q <= 5'h00;
		else if (txTick)
			txCnt_q <= 5'h00;
		else if (tick)
			txCnt_q <= txCnt_q + 5'h01;
	end

	// Transmitter
	always_ff @(posedge clk) begin
		if (reset) begin
			txState_q <= ubff_pkg::UBFF_IDLE;
			txLine <= 1'b1;
			txShift_q <= 8'h00;
			txBits_q <= 3'h0;
			txPar_q <= 1'b0;
		end else begin
			case (txState_q)
				ubff_pkg::UBFF_IDLE: begin
					txLine <= 1'b1;
					if (txStart) begin
						txShift_q <= charMask(wbDatI[7:0], mode.eightBit);
						txPar_q <= ^charMask(wbDatI[7:0], mode.eightBit);
						txLine <= 1'b0;
						txState_q <= ubff_pkg::UBFF_START;
					end
				end
				ubff_pkg::UBFF_START: if (txTick) begin
					txLine <= txShift_q[0];
					txShift_q <= txShift_q >> 1;
					txBits_q <= mode.eightBit ? 3'h7 : 3'h6;
					txState_q <= ubff_pkg::UBFF_DATA;
				end
				ubff_pkg::UBFF_DATA: if (txTick) begin
					if (txBits_q != 3'h0) begin
						txLine <= txShift_q[0];
						txShift_q <= txShift_q >> 1;
						txBits_q <= txBits_q - 3'h1;
					end else if (mode.parity != ubff_pkg::UBFF_PAR_NONE) begin
						case (mode.parity)
							ubff_pkg::UBFF_PAR_EVEN: txLine <= txPar_q;
							ubff_pkg::UBFF_PAR_ODD: txLine <= ~txPar_q;
							default: txLine <= 1'b0;
						endcase
						txState_q <= ubff_pkg::UBFF_PARITY;
					end else begin
						txLine <= 1'b1;
						txState_q <= ubff_pkg::UBFF_STOP1;
					end
				end
				ubff_pkg::UBFF_PARITY: if (txTick) begin
					txLine <= 1'b1;
					txState_q <= ubff_pkg::UBFF_STOP1;
				end
				ubff_pkg::UBFF_STOP1: if (txTick) begin
					txLine <= 1'b1;
					txState_q <= mode.twoStop ? ubff_pkg::UBFF_STOP2 : ubff_pkg::UBFF_IDLE;
				end
				ubff_pkg::UBFF_STOP2: if (txTick)
					txState_q <= ubff_pkg::UBFF_IDLE;
				default: txState_q <= ubff_pkg::UBFF_IDLE;
			endcase
		end
	end
	assign txDone = txTick && ((txState_q == ubff_pkg::UBFF_STOP2)
		|| (txState_q == ubff_pkg::UBFF_STOP1 && !mode.twoStop));

	// Receiver counter starts at the start edge and runs freely per bit
	always_ff @(posedge clk) begin
		if (reset || rxState_q == ubff_pkg::UBFF_IDLE)
			rxCnt_q <= 5'h00;
		else if (rxTick)
			rxCnt_q <= 5'h00;
		else if (tick)
			rxCnt_q <= rxCnt_q + 5'h01;
	end

	assign rxStopOk = rxLine;
	always_comb begin
		rxErr.parityErr = 1'b0;
		case (mode.parity)
			ubff_pkg::UBFF_PAR_EVEN: rxErr.parityErr = ^{rxShift_q, rxPar_q};
			ubff_pkg::UBFF_PAR_ODD: rxErr.parityErr = ~^{rxShift_q, rxPar_q};
			default: rxErr.parityErr = 1'b0;
		endcase
		rxErr.framingErr = !rxStopOk;
		rxErr.overrunErr = rxFull_q;
	end

	// Sampling at mid-bit; stop sampled once only
	always_ff @(posedge clk) begin
		if (reset || !mode.rxEnable) begin
			rxState_q <= ubff_pkg::UBFF_IDLE;
			rxShift_q <= 8'h00;
			rxBits_q <= 3'h0;
			rxPar_q <= 1'b0;
		end else begin
			case (rxState_q)
				ubff_pkg::UBFF_IDLE: if (!rxLine) begin
					rxState_q <= ubff_pkg::UBFF_START;
				end
				// Start confirmed at its middle, so bit 0 is sampled one bit later
				ubff_pkg::UBFF_START: if (rxMid) begin
					if (rxLine) begin
						rxState_q <= ubff_pkg::UBFF_IDLE;
					end else begin
						rxState_q <= ubff_pkg::UBFF_DATA;
						rxShift_q <= 8'h00;
						rxBits_q <= mode.eightBit ? 3'h7 : 3'h6;
					end
				end
				ubff_pkg::UBFF_DATA: if (rxMid) begin
					if (mode.eightBit)
						rxShift_q <= {rxLine, rxShift_q[7:1]};
					else
						rxShift_q <= {1'b0, rxLine, rxShift_q[6:1]};
					rxBits_q <= rxBits_q - 3'h1;
					if (rxBits_q == 3'h0)
						rxState_q <= (mode.parity == ubff_pkg::UBFF_PAR_NONE) ? ubff_pkg::UBFF_STOP1
							: ubff_pkg::UBFF_PARITY;
				end
				ubff_pkg::UBFF_PARITY: if (rxMid) begin
					rxPar_q <= rxLine;
					rxState_q <= ubff_pkg::UBFF_STOP1;
				end
				ubff_pkg::UBFF_STOP1: if (rxMid)
					rxState_q <= ubff_pkg::UBFF_IDLE;
				default: rxState_q <= ubff_pkg::UBFF_IDLE;
			endcase
		end
	end
	assign rxDone = mode.rxEnable && rxMid && (rxState_q == ubff_pkg::UBFF_STOP1);

	// Buffer, error status; reading data clears errors, frame arrival overwrites
	always_ff @(posedge clk) begin
		if (reset) begin
			rxBuf_q <= 8'h00;
			rxFull_q <= 1'b0;
			errStat_q <= 3'h0;
		end else if (rxDone) begin
			rxBuf_q <= charMask(rxShift_q, mode.eightBit);
			rxFull_q <= 1'b1;
			if (mode.parity == ubff_pkg::UBFF_PAR_NONE)
				errStat_q <= {1'b0, rxErr.framingErr, rxErr.overrunErr};
			else
				errStat_q <= rxErr;
		end else if (wbRead && wbAdr[7:2] == 6'(`UBFF_OFS_RXDATA >> 2)) begin
			rxFull_q <= 1'b0;
			errStat_q <= 3'h0;
		end
	end

	// Sticky events; a set in the clear cycle wins
	always_ff @(posedge clk) begin
		if (reset) begin
			irqStat_q <= 3'h0;
			irq <= 1'b0;
		end else begin
			for (int b = 0; b < 3; b++) begin
				if (wbWrite && selByte(wbAdr, `UBFF_OFS_IRQSTAT, wbSel) && wbDatI[b])
					irqStat_q[b] <= 1'b0;
			end
			if (txDone)
				irqStat_q[`UBFF_IRQ_TXDONE] <= 1'b1;
			if (rxDone)
				irqStat_q[`UBFF_IRQ_RXDONE] <= 1'b1;
			if (rxDone && (rxErr.framingErr || rxErr.overrunErr
				|| (rxErr.parityErr && mode.parity[1])))
				irqStat_q[`UBFF_IRQ_RXERR] <= 1'b1;
			irq <= |(irqStat_q & irqMask_q);
		end
	end
endmodule // ubff_uart
`default_nettype wire

/* tb/ubff_peer.sv */
// Purpose: Remote serial peer for the baud and frame block
// Assumes: Bit length in clocks is set by the bench before use
// Notes: Samples txLine at mid-bit, drives rxLine frame by frame
`timescale 1ns/10ps
`default_nettype none
module ubff_peer (
	input wire logic clk, // System clock
	input wire logic txLine, // Line from the block
	output logic rxLine // Line into the block
);
	int bitLen = 64;
	initial rxLine = 1'b1;
	task automatic send(input logic [11:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			rxLine <= bits[i];
			repeat (bitLen) @(posedge clk);
		end
		rxLine <= 1'b1;
	endtask
	task automatic recv(input int n, output logic [11:0] bits, output bit ok);
		int w;
		bits = 12'hFFF;
		for (w = 0; w < 9999 && txLine; w++)
			@(posedge clk);
		ok = !txLine;
		// Mid-bit sampling gives the widest margin
		for (int i = 0; i < n; i++) begin
			repeat (i ? bitLen : bitLen / 2) @(posedge clk);
			bits[i] = txLine;
		end
	endtask
endmodule // ubff_peer
`default_nettype wire

/* tb/ubff_uart_chk.sv */
// Purpose: Port-level assertions for the baud and frame block
// Assumes: One clock, synchronous active-high reset
// Notes: Shortest bit time is 64 clocks; start bit may lose one prescale period
`timescale 1ns/10ps
`default_nettype none
module ubff_uart_chk (
	input wire logic clk, // System clock
	input wire logic reset, // Sync reset
	input wire logic wbCyc, // Cycle
	input wire logic wbStb, // Strobe
	input wire logic wbWe, // Write enable
	input wire logic [7:0] wbAdr, // Byte address
	input wire logic [3:0] wbSel, // Byte selects
	input wire logic [31:0] wbDatI, // Write data
	input wire logic [31:0] wbDatO, // Read data
	input wire logic wbAck, // Acknowledge
	input wire logic rxLine, // Serial in
	input wire logic txLine, // Serial out
	input wire logic irq // Interrupt
);
	logic [19:0] lowRun_q;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	sequence sReq;
		wbCyc && wbStb && !wbAck;
	endsequence
	sequence sRead;
		wbAck && !wbWe;
	endsequence
	always_ff @(posedge clk) begin
		lowRun_q <= (reset || txLine) ? 20'h00000 : lowRun_q + 20'h00001;
	end
	chk_ack_next: assert property (sReq |=> wbAck) else $error("ack missing after request");
	chk_ack_pulse: assert property (wbAck |=> !wbAck) else $error("ack longer than one cycle");
	chk_ack_cause: assert property ($rose(wbAck) |-> $past(wbCyc && wbStb)) else $error("ack without request");
	chk_unmapped_zero: assert property (sRead ##0 (wbAdr > 8'h1B) |-> wbDatO == 32'h00000000)
		else $error("unmapped read not zero");
	chk_err_width: assert property (sRead ##0 (wbAdr[7:2] == 6'h01) |-> wbDatO[31:3] == 29'h00000000)
		else $error("error status upper bits set");
	chk_baud_width: assert property (sRead ##0 (wbAdr[7:2] == 6'h02) |-> wbDatO[31:7] == 25'h0000000)
		else $error("baud upper bits set");
	chk_mode_width: assert property (sRead ##0 (wbAdr[7:2] == 6'h00) |-> wbDatO[0] == 1'b0 && wbDatO[31:8] == 24'h000000)
		else $error("mode unused bits set");
	chk_reset_idle: assert property ($fell(reset) |-> txLine && !wbAck && !irq)
		else $error("outputs not idle after reset");
	chk_low_min: assert property ($rose(txLine) |-> lowRun_q >= 20'h0003D)
		else $error("low period shorter than one bit");
endmodule // ubff_uart_chk
bind ubff_uart ubff_uart_chk chk (.clk, .reset, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatI, .wbDatO, .wbAck,
	.rxLine, .txLine, .irq);
`default_nettype wire

/* tb/ubff_uart_tb.sv */
// Purpose: Self-checking bench for the baud and frame block
// Assumes: Peer model on the line pair, Wishbone master tasks here
// Notes: Random frame settings from a fixed seed, corner cases first
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checkCount++; if ((a) !== (b)) begin failures++; $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module ubff_uart_tb;
	logic clk = 1'b0, reset = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
	logic [7:0] wbAdr = 8'h00;
	logic [3:0] wbSel = 4'hF;
	logic [31:0] wbDatI = 32'h00000000, wbDatO, rd;
	logic wbAck, rxLine, txLine, irq;
	int failures = 0, checkCount = 0, seed = 32'hE57A790A;
	always #10 clk = ~clk;
	ubff_uart dut (.clk(clk), .reset(reset), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
		.wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .rxLine(rxLine), .txLine(txLine), .irq(irq));
	ubff_peer peer (.clk(clk), .txLine(txLine), .rxLine(rxLine));
	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", checkCount, failures);
		if (failures == 0 && checkCount > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
		int w;
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbDatI <= {24'h000000, d};
		for (w = 0; w < 50; w++) begin
			@(posedge clk);
			if (wbAck === 1'b1)
				break;
		end
		r = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		if (w == 50) begin
			failures++;
			complete_run();
		end
		@(posedge clk);
	endtask
	// Line bits, start first; bad[0] flips parity, bad[1] drops the first stop
	function automatic logic [11:0] frame(logic [7:0] d, logic [1:0] par, logic eight, two, logic [1:0] bad,
		output int n);
		logic [7:0] v;
		v = d & {eight, 7'h7F};
		frame = 12'hFFE;
		n = 1;
		for (int i = 0; i < 7 + eight; i++) begin
			frame[n] = v[i];
			n++;
		end
		if (par != 2'h0) begin
			frame[n] = (par[1] & (^v ^ !par[0])) ^ bad[0];
			n++;
		end
		frame[n] = !bad[1];
		n += 1 + two;
	endfunction
	initial begin
		logic [7:0] d;
		logic [1:0] par, bad;
		logic [2:0] ps;
		logic [3:0] k;
		logic eight, two, ovr;
		logic [11:0] f, got;
		int n, m, c;
		bit ok;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		for (int a = 0; a < 32; a += 4) begin
			if (a != 12 && a != 16) begin
				wb(1'b0, 8'(a), 8'h00, rd);
				`CHK(rd, 32'h00000000)
			end
		end
		wb(1'b1, 8'h18, 8'h01, rd);
		for (int it = 0; it < 10; it++) begin
			{d, par, eight, two, bad, ovr} = 15'($random(seed));
			ps = 3'($unsigned($random(seed)) % 3);
			k = 4'($unsigned($random(seed)) % 15);
			if (it == 0)
				{ps, k, par, bad, ovr} = {3'h2, 4'hE, 2'h3, 2'h1, 1'b0};
			if (it == 1)
				{ps, k, par, eight, bad, ovr} = {3'h0, 4'h0, 2'h2, 1'b0, 2'h3, 1'b0};
			if (ovr)
				bad[1] = 1'b0;
			m = (4 << ps) * (16 + k);
			peer.bitLen = m;
			wb(1'b1, 8'h00, {3'h0, par, eight, two, 1'b0}, rd);
			wb(1'b1, 8'h08, {1'b0, ps, k}, rd);
			wb(1'b0, 8'h08, 8'h00, rd);
			`CHK(rd, {25'h0000000, ps, k})
			wb(1'b1, 8'h00, {3'h6, par, eight, two, 1'b0}, rd);
			wb(1'b1, 8'h14, 8'h07, rd);
			f = frame(d, par, eight, two, 2'h0, n);
			wb(1'b1, 8'h0C, d, rd);
			fork
				peer.recv(n, got, ok);
				for (c = 0; c < 9999 && irq !== 1'b1; c++)
					@(posedge clk);
			join
			`CHK(ok, 1'b1)
			`CHK(got, f)
			`CHK(c >= n * m - m / 2 && c <= n * m + 4, 1'b1)
			wb(1'b1, 8'h14, 8'h01, rd);
			f = frame(d, par, eight, two, bad, n);
			peer.send(f, n);
			if (ovr) begin
				f = frame(~d, par, eight, two, 2'h0, n);
				peer.send(f, n);
			end
			wb(1'b0, 8'h04, 8'h00, rd);
			`CHK(rd, {29'h00000000, bad[0] & par[1] & !ovr, bad[1], ovr})
			wb(1'b0, 8'h10, 8'h00, rd);
			`CHK(rd, {24'h000000, (ovr ? ~d : d) & {eight, 7'h7F}})
			wb(1'b0, 8'h14, 8'h00, rd);
			`CHK(rd, {29'h00000000, ovr | bad[1] | (bad[0] & par[1]), 2'h2})
			`CHK(irq, 1'b0)
		end
		complete_run();
	end
endmodule // ubff_uart_tb
`default_nettype wire
